// ==== common/sfh_pkg.sv ====
// package of constants and types for the semaphore flag host controller
package sfh_pkg;

   // ----------------------------------------
   // pin geometry
   // ----------------------------------------
   localparam int SFH_ADDR_W = 18;
   localparam int SFH_DATA_W = 36;
   localparam int SFH_LANES = 4;
   localparam int SFH_IDX_W = 3;
   localparam logic [2:0] SFH_LAST_IDX = 3'h7;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int SFH_CLK_NS = 5;
   localparam int SFH_WR_NS = 20;
   localparam int SFH_RD_NS = 30;
   localparam int SFH_WR_CYC = (SFH_WR_NS + SFH_CLK_NS - 1) / SFH_CLK_NS;
   localparam int SFH_RD_CYC = (SFH_RD_NS + SFH_CLK_NS - 1) / SFH_CLK_NS;
   localparam logic [3:0] SFH_WR_LAST = 4'(SFH_WR_CYC - 1);
   localparam logic [3:0] SFH_RD_LAST = 4'(SFH_RD_CYC - 1);
   localparam logic [3:0] SFH_STB_FIRST = 4'h1;
   localparam logic [3:0] SFH_STB_LAST = 4'(SFH_WR_CYC - 2);

   // ----------------------------------------
   // reset and flag values
   // ----------------------------------------
   localparam logic SFH_FLAG_RST = 1'b1;
   localparam logic SFH_FREE = 1'b1;
   localparam logic SFH_TAKE = 1'b0;

   // ----------------------------------------
   // commands and states
   // ----------------------------------------
   typedef enum logic [1:0] {
      SFH_OP_READ,
      SFH_OP_CLAIM,
      SFH_OP_RELEASE,
      SFH_OP_INIT
   } sfh_op_type;

   typedef enum logic [2:0] {
      SFH_S_IDLE,
      SFH_S_WR,
      SFH_S_WGAP,
      SFH_S_RD,
      SFH_S_RGAP,
      SFH_S_RESP
   } sfh_state_type;

endpackage

// ==== design/sfh_host.sv ====
// host controller that claims, releases and reads the eight semaphore flags of one RAM port
`timescale 1ns/100ps
module sfh_host
   import sfh_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // user side
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [1:0] cmd_op_i,
   input wire logic [SFH_IDX_W-1:0] cmd_index_i,
   input wire logic claim_retry_i,
   output logic resp_valid_o,
   output logic resp_granted_o,
   output logic resp_flag_o,
   // ram port pins
   output logic token_space_select_n_o,
   output logic chip_select_low_n_o,
   output logic chip_select_high_o,
   output logic write_not_read_o,
   output logic output_enable_n_o,
   output logic [SFH_LANES-1:0] byte_lane_strobe_n_o,
   output logic [SFH_ADDR_W-1:0] addr_o,
   input wire logic [SFH_DATA_W-1:0] data_i,
   output logic [SFH_DATA_W-1:0] data_o,
   output logic data_oe_n_o
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   sfh_state_type st, next_st;
   sfh_op_type op, next_op;
   logic [3:0] cnt, next_cnt;
   logic [SFH_IDX_W-1:0] idx, next_idx;
   logic val, next_val;
   logic withdraw, next_withdraw;
   logic rd_flag, next_rd_flag;
   logic written, next_written;
   logic [SFH_DATA_W-1:0] data_meta, data_sync;

   // data pins cross from the asynchronous RAM, so two flops first
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         data_meta <= '0;
         data_sync <= '0;
      end else begin
         data_meta <= data_i;
         data_sync <= data_meta;
      end
   end

   always_comb begin
      next_st = st;
      next_op = op;
      next_cnt = cnt;
      next_idx = idx;
      next_val = val;
      next_withdraw = withdraw;
      next_rd_flag = rd_flag;
      next_written = written;
      case (st)
         SFH_S_IDLE: begin
            if (cmd_valid_i) begin
               next_op = sfh_op_type'(cmd_op_i);
               next_idx = cmd_index_i;
               next_cnt = 4'h0;
               next_withdraw = 1'b0;
               next_written = 1'b0;
               next_st = SFH_S_WR;
               case (sfh_op_type'(cmd_op_i))
                  SFH_OP_READ: next_st = SFH_S_RD;
                  SFH_OP_CLAIM: next_val = SFH_TAKE;
                  SFH_OP_RELEASE: next_val = SFH_FREE;
                  SFH_OP_INIT: begin
                     next_idx = '0;
                     next_val = SFH_FREE;
                  end
                  default: next_st = SFH_S_IDLE;
               endcase
            end
         end
         SFH_S_WR: begin
            if (cnt == SFH_WR_LAST) begin
               next_cnt = 4'h0;
               next_written = (val == SFH_TAKE);
               next_st = SFH_S_WGAP;
            end else begin
               next_cnt = cnt + 4'h1;
            end
         end
         SFH_S_WGAP: begin
            if (op == SFH_OP_CLAIM && !withdraw) begin
               next_st = SFH_S_RD;
            end else if (op == SFH_OP_INIT && idx != SFH_LAST_IDX) begin
               next_idx = idx + 3'h1;
               next_st = SFH_S_WR;
            end else begin
               next_st = SFH_S_RESP;
            end
         end
         SFH_S_RD: begin
            if (cnt == SFH_RD_LAST) begin
               next_cnt = 4'h0;
               // every data bit carries the flag; bit 0 stands for all
               next_rd_flag = data_sync[0];
               next_st = SFH_S_RGAP;
            end else begin
               next_cnt = cnt + 4'h1;
            end
         end
         SFH_S_RGAP: begin
            if (op == SFH_OP_CLAIM && rd_flag) begin
               if (claim_retry_i) begin
                  next_st = SFH_S_RD;
               end else begin
                  // a stale request would grab the token later unasked
                  next_withdraw = 1'b1;
                  next_val = SFH_FREE;
                  next_st = SFH_S_WR;
               end
            end else begin
               next_st = SFH_S_RESP;
            end
         end
         SFH_S_RESP: next_st = SFH_S_IDLE;
         default: next_st = SFH_S_IDLE;
      endcase
   end

   // power-up starts with the init sweep: the flags have no reset of their own
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= SFH_S_WR;
         op <= SFH_OP_INIT;
         cnt <= 4'hF; // wraps to zero, so select leads the first strobe
         idx <= '0;
         val <= SFH_FREE;
         withdraw <= 1'b0;
         rd_flag <= SFH_FLAG_RST;
         written <= 1'b0;
      end else begin
         st <= next_st;
         op <= next_op;
         cnt <= next_cnt;
         idx <= next_idx;
         val <= next_val;
         withdraw <= next_withdraw;
         rd_flag <= next_rd_flag;
         written <= next_written;
      end
   end

   // ----------------------------------------
   // pin drive
   // ----------------------------------------
   logic next_sel_n, next_wnr, next_oe_n, next_doe_n;

   always_comb begin
      next_sel_n = !(next_st == SFH_S_WR || next_st == SFH_S_RD);
      // strobe sits inside the address window for setup and hold
      next_wnr = !(next_st == SFH_S_WR && next_cnt >= SFH_STB_FIRST
                   && next_cnt <= SFH_STB_LAST);
      next_oe_n = !(next_st == SFH_S_RD);
      next_doe_n = !(next_st == SFH_S_WR);
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         token_space_select_n_o <= 1'b1;
         write_not_read_o <= 1'b1;
         output_enable_n_o <= 1'b1;
         byte_lane_strobe_n_o <= '1;
         addr_o <= '0;
         data_o <= '0;
         data_oe_n_o <= 1'b1;
      end else begin
         token_space_select_n_o <= next_sel_n;
         write_not_read_o <= next_wnr;
         output_enable_n_o <= next_oe_n;
         byte_lane_strobe_n_o <= {SFH_LANES{next_sel_n}};
         addr_o <= SFH_ADDR_W'(next_idx);
         data_o <= {SFH_DATA_W{next_val}};
         data_oe_n_o <= next_doe_n;
      end
   end

   // the memory array is never selected by this controller
   assign chip_select_low_n_o = 1'b1;
   assign chip_select_high_o = 1'b0;

   assign cmd_ready_o = (st == SFH_S_IDLE);
   assign resp_valid_o = (st == SFH_S_RESP);
   assign resp_flag_o = rd_flag;
   assign resp_granted_o = (st == SFH_S_RESP) && op == SFH_OP_CLAIM && !withdraw && !rd_flag;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_write_phase;
      st == SFH_S_WR && cnt == SFH_WR_LAST ##1 st == SFH_S_WGAP;
   endsequence

   sequence s_failed_read;
      st == SFH_S_RGAP && op == SFH_OP_CLAIM && rd_flag && !claim_retry_i;
   endsequence

   property p_sel_strobes;
      @(posedge clk_i) disable iff (sys_rst_i)
      !token_space_select_n_o |-> byte_lane_strobe_n_o == '0;
   endproperty
   a_sel_strobes: assert property (p_sel_strobes)
      else $error("byte strobes not active with semaphore select");

   property p_cs_off;
      @(posedge clk_i) disable iff (sys_rst_i)
      !token_space_select_n_o |-> chip_select_low_n_o && !chip_select_high_o;
   endproperty
   a_cs_off: assert property (p_cs_off)
      else $error("memory chip select active during semaphore access");

   property p_read_pins;
      @(posedge clk_i) disable iff (sys_rst_i)
      !output_enable_n_o |-> !token_space_select_n_o && byte_lane_strobe_n_o == '0
         && write_not_read_o && data_oe_n_o;
   endproperty
   a_read_pins: assert property (p_read_pins)
      else $error("semaphore read without full select");

   property p_strobe_setup;
      @(posedge clk_i) disable iff (sys_rst_i)
      $fell(write_not_read_o) |-> $past(!token_space_select_n_o) && !data_oe_n_o
         ##1 !token_space_select_n_o;
   endproperty
   a_strobe_setup: assert property (p_strobe_setup)
      else $error("write strobe outside address window");

   property p_write_value;
      @(posedge clk_i) disable iff (sys_rst_i)
      !write_not_read_o && op == SFH_OP_CLAIM && !withdraw |-> data_o[0] == SFH_TAKE;
   endproperty
   a_write_value: assert property (p_write_value)
      else $error("claim did not drive zero on bit 0");

   property p_claim_order;
      @(posedge clk_i) disable iff (sys_rst_i)
      st == SFH_S_RD && op == SFH_OP_CLAIM |-> written;
   endproperty
   a_claim_order: assert property (p_claim_order)
      else $error("claim read before zero was written");

   property p_claim_then_read;
      @(posedge clk_i) disable iff (sys_rst_i)
      s_write_phase ##0 (op == SFH_OP_CLAIM && !withdraw) |=> st == SFH_S_RD;
   endproperty
   a_claim_then_read: assert property (p_claim_then_read)
      else $error("claim write not followed by read-back");

   property p_withdraw;
      @(posedge clk_i) disable iff (sys_rst_i)
      s_failed_read |=> st == SFH_S_WR && val == SFH_FREE ##[1:8] !write_not_read_o;
   endproperty
   a_withdraw: assert property (p_withdraw)
      else $error("failed claim not withdrawn with a one");

   property p_init_all;
      @(posedge clk_i) disable iff (sys_rst_i)
      st == SFH_S_RESP && op == SFH_OP_INIT |-> idx == SFH_LAST_IDX && val == SFH_FREE;
   endproperty
   a_init_all: assert property (p_init_all)
      else $error("init ended before all eight flags were freed");

endmodule

// ==== verif/sfh_sem_model.sv ====
// behavioural two-port semaphore flag device seen by the host bench
`timescale 1ns/100ps
module sfh_token_model (
   input wire logic a_sel_n_i,
   input wire logic a_csl_n_i,
   input wire logic a_csh_i,
   input wire logic a_wnr_i,
   input wire logic a_oe_n_i,
   input wire logic [3:0] a_stb_n_i,
   input wire logic [17:0] a_addr_i,
   input wire logic [35:0] a_data_i,
   output logic [35:0] a_data_o,
   input wire logic b_sel_n_i,
   input wire logic b_wnr_i,
   input wire logic b_oe_n_i,
   input wire logic [2:0] b_addr_i,
   input wire logic b_data_i,
   output logic [35:0] b_data_o,
   output logic bad_o
);
   // ----------------------------------------
   // token state
   // ----------------------------------------
   // no reset: unknown until one side writes a one after the other side has written
   logic [1:0] own [8]; // 0 free, 1 port a, 2 port b
   logic req [2][8];
   logic [35:0] qa = '0;
   logic [35:0] qb = '0;
   initial bad_o = 1'b0;

   function automatic logic flag(input int p, input logic [2:0] i);
      if (own[i] === 2'(p + 1)) return 1'b0;
      if (^own[i] === 1'bx) return 1'bx;
      return 1'b1;
   endfunction

   task automatic wr(input int p, input logic [2:0] i, input logic v);
      if (v === 1'b0) begin
         req[p][i] = 1'b0;
         if (own[i] === 2'h0) own[i] = 2'(p + 1);
      end else begin
         req[p][i] = 1'b1;
         if (own[i] !== 2'(2 - p)) begin
            own[i] = (req[1-p][i] === 1'b0) ? 2'(2 - p) :
               ((req[1-p][i] === 1'b1) ? 2'h0 : 2'bxx);
         end
      end
   endtask

   // ----------------------------------------
   // port access
   // ----------------------------------------
   always @(posedge a_wnr_i) begin
      if (!a_sel_n_i) begin
         if (a_stb_n_i !== 4'h0) bad_o = 1'b1;
         wr(0, a_addr_i[2:0], a_data_i[0]);
      end
   end
   always @(posedge b_wnr_i) if (!b_sel_n_i) wr(1, b_addr_i, b_data_i);
   // short delay so select and enable that fall together are both seen
   always @(negedge a_oe_n_i) begin
      #1;
      if (!a_sel_n_i) begin
         qa = {36{flag(0, a_addr_i[2:0])}};
         if (a_stb_n_i !== 4'h0) bad_o = 1'b1;
      end
   end
   always @(negedge b_oe_n_i) begin
      #1;
      if (!b_sel_n_i) qb = {36{flag(1, b_addr_i)}};
   end
   always @(negedge a_sel_n_i) begin
      #1;
      if (a_csl_n_i !== 1'b1 || a_csh_i !== 1'b0) bad_o = 1'b1;
   end
   // released lines show the inverse, never a stale value
   assign a_data_o = (!a_sel_n_i && !a_oe_n_i) ? qa : ~qa;
   assign b_data_o = (!b_sel_n_i && !b_oe_n_i) ? qb : ~qb;
endmodule

// ==== verif/sfh_host_tb.sv ====
// self-checking bench for the semaphore flag host controller
`timescale 1ns/100ps
module sfh_host_tb;
   import sfh_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cv = 1'b0;
   logic [1:0] cop = 2'h0;
   logic [2:0] cix = 3'h0;
   logic rt = 1'b0;
   logic rdy, rv, gr, rf, sel_n, csl_n, csh, wnr, oe_n, doe_n, bad;
   logic [3:0] stb_n;
   logic [17:0] addr;
   logic [35:0] dout, din, mq, bq, q;
   logic b_sel_n = 1'b1;
   logic b_wnr = 1'b1;
   logic b_oe_n = 1'b1;
   logic b_d = 1'b1;
   logic [2:0] b_addr = 3'h0;
   logic g, f;
   int k;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   assign din = doe_n ? mq : dout;

   always #2.5 clk_i = ~clk_i;

   sfh_host uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cv), .cmd_ready_o(rdy),
      .cmd_op_i(cop), .cmd_index_i(cix), .claim_retry_i(rt), .resp_valid_o(rv),
      .resp_granted_o(gr), .resp_flag_o(rf), .token_space_select_n_o(sel_n),
      .chip_select_low_n_o(csl_n), .chip_select_high_o(csh), .write_not_read_o(wnr),
      .output_enable_n_o(oe_n), .byte_lane_strobe_n_o(stb_n), .addr_o(addr), .data_i(din),
      .data_o(dout), .data_oe_n_o(doe_n));

   sfh_token_model dev (.a_sel_n_i(sel_n), .a_csl_n_i(csl_n), .a_csh_i(csh), .a_wnr_i(wnr),
      .a_oe_n_i(oe_n), .a_stb_n_i(stb_n), .a_addr_i(addr), .a_data_i(dout), .a_data_o(mq),
      .b_sel_n_i(b_sel_n), .b_wnr_i(b_wnr), .b_oe_n_i(b_oe_n), .b_addr_i(b_addr),
      .b_data_i(b_d), .b_data_o(bq), .bad_o(bad));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic stop_test();
      if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("[FAIL] %0t timeout", $time);
         stop_test();
      end
   end

   task automatic host(input logic [1:0] op, input logic [2:0] ix, input logic r);
      @(negedge clk_i);
      while (rdy !== 1'b1) @(negedge clk_i);
      cv = 1'b1;
      cop = op;
      cix = ix;
      rt = r;
      @(posedge clk_i);
      k = 0;
      do begin
         @(negedge clk_i);
         cv = 1'b0;
         k++;
      end while (rv !== 1'b1 && k < 500);
      g = gr;
      f = rf;
   endtask

   task automatic b_write(input logic [2:0] ix, input logic v);
      @(negedge clk_i);
      b_sel_n = 1'b0;
      b_addr = ix;
      b_d = v;
      @(negedge clk_i);
      b_wnr = 1'b0;
      @(negedge clk_i);
      b_wnr = 1'b1;
      @(negedge clk_i);
      b_sel_n = 1'b1;
   endtask

   task automatic b_read(input logic [2:0] ix);
      @(negedge clk_i);
      b_sel_n = 1'b0;
      b_oe_n = 1'b0;
      b_addr = ix;
      repeat (3) @(negedge clk_i);
      q = bq;
      b_sel_n = 1'b1;
      b_oe_n = 1'b1;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_init();
      k = 0;
      while (rv !== 1'b1 && k < 200) begin
         @(negedge clk_i);
         k++;
      end
      check(rv === 1'b1, "no init response");
      for (int i = 0; i < 8; i++) b_write(3'(i), 1'b1);
      for (int i = 0; i < 8; i++) begin
         host(SFH_OP_READ, 3'(i), 1'b0);
         check(f === 1'b1 && k == 8, "flag not free");
      end
   endtask

   task automatic t_claim();
      host(SFH_OP_CLAIM, 3'h5, 1'b0);
      check(g === 1'b1 && f === 1'b0 && k == 13, "claim free");
      b_read(3'h5);
      check(q === {36{1'b1}}, "other side not one");
      b_write(3'h5, 1'b0);
      host(SFH_OP_READ, 3'h5, 1'b0);
      check(f === 1'b0, "owner lost token");
      host(SFH_OP_RELEASE, 3'h5, 1'b0);
      check(k == 6, "release timing");
      b_read(3'h5);
      check(q === 36'h0, "no handoff");
      b_write(3'h5, 1'b1);
      host(SFH_OP_READ, 3'h5, 1'b0);
      check(f === 1'b1, "not freed");
   endtask

   task automatic t_busy();
      b_write(3'h2, 1'b0);
      host(SFH_OP_CLAIM, 3'h2, 1'b0);
      check(g === 1'b0 && f === 1'b1 && k == 18, "claim of busy flag");
      b_write(3'h2, 1'b1);
      b_read(3'h2);
      check(q === {36{1'b1}}, "withdrawn request kept");
      host(SFH_OP_READ, 3'h2, 1'b0);
      check(f === 1'b1, "stale request took the flag");
   endtask

   task automatic t_retry();
      b_write(3'h3, 1'b0);
      fork
         host(SFH_OP_CLAIM, 3'h3, 1'b1);
         begin
            repeat (60) @(negedge clk_i);
            b_write(3'h3, 1'b1);
         end
      join
      check(g === 1'b1 && k > 60, "retry claim");
      host(SFH_OP_RELEASE, 3'h3, 1'b0);
      b_read(3'h3);
      check(q === {36{1'b1}}, "release after retry");
   endtask

   task automatic t_all();
      for (int i = 0; i < 8; i++) begin
         host(SFH_OP_CLAIM, 3'(i), 1'b0);
         b_write(3'(i), 1'b0);
         b_read(3'(i));
         check(g === 1'b1 && q === {36{1'b1}}, "claim each flag");
         host(SFH_OP_RELEASE, 3'(i), 1'b0);
         b_read(3'(i));
         check(q === 36'h0, "flag index mixed up");
         b_write(3'(i), 1'b1);
      end
      host(SFH_OP_INIT, 3'h0, 1'b0);
      check(rv === 1'b1 && rdy === 1'b0 && k == 41, "init command");
      check(bad === 1'b0, "pin protocol broken");
   endtask

   initial begin
      repeat (3) @(negedge clk_i);
      sys_rst_i = 1'b0;
      t_init();
      t_claim();
      t_busy();
      t_retry();
      t_all();
      stop_test();
   end
endmodule
